// ==== verilog/sich_regs.vh ====
// constants of the sensor info command handler: command codes, counts, error codes, limits
`ifndef SICH_REGS_VH
`define SICH_REGS_VH

// command numbers
`define SICH_CMD_LEARN_LEFT   8'hA1
`define SICH_CMD_RANGES       8'hA2
`define SICH_CMD_GET_CAPACITY 8'hA4
`define SICH_CMD_SET_CAPACITY 8'hA5
`define SICH_CMD_GET_RATED    8'hA6
`define SICH_CMD_SET_RATED    8'hA7
`define SICH_CMD_TEXT_ASSIGN  8'hA8

// parameter byte counts
`define SICH_NPAR_RANGES      3'h1
`define SICH_NPAR_SET_VALUE   3'h4

// reply byte counts
`define SICH_NREP_LEARN       3'h2
`define SICH_NREP_RANGES      3'h4
`define SICH_NREP_VALUE       3'h4
`define SICH_NREP_ASSIGN      3'h2
`define SICH_NREP_ERROR       3'h1
`define SICH_NREP_NONE        3'h0

// error codes
`define SICH_ERR_BUSY         8'hA0
`define SICH_ERR_EXPONENT     8'h54
`define SICH_ERR_MANTISSA     8'h55
`define SICH_ERR_MISMATCH     8'h56
`define SICH_ERR_RANGE_PARAM  8'h59
`define SICH_ERR_NO_VALUE     8'h91

// range query parameter codes
`define SICH_RQ_CURRENT       8'h00
`define SICH_RQ_POS1_LVL1     8'h01
`define SICH_RQ_POS2_LVL1     8'h02
`define SICH_RQ_POS2_LVL2     8'h03
`define SICH_RQ_CH1_ACTIVE    8'h10
`define SICH_RQ_CH1           8'h11

// jumper group identifiers
`define SICH_GID_POS1         8'h01
`define SICH_GID_POS2         8'h02
`define SICH_GID_CH1          8'h03
`define SICH_GID_ERROR        8'hFF

// value limits of the stored characteristic values
`define SICH_CAP_EXP_MAX      8'h07
`define SICH_CAP_MANT_MIN     24'h01_86A0
`define SICH_RATED_EXP_MAX    8'h03
`define SICH_RATED_MANT_MIN   24'h00_2710
`define SICH_MANT_MAX         24'h98_967F

// reset values
`define SICH_RESET_BYTE       8'h00
`define SICH_RESET_WORD       32'h0000_0000

`endif

// ==== verilog/sich_value_store.v ====
// storage of the physical and electrical characteristic values
`timescale 1ns/1ps
`default_nettype none
`include "sich_regs.vh"

module sich_value_store (
   // clock and reset
   input  wire        clock,
   input  wire        reset,
   // write side
   input  wire        wr_en,
   input  wire        wr_sel,
   input  wire [31:0] wr_data,
   // read side
   input  wire        rd_sel,
   output reg  [31:0] rd_data,
   output reg         rd_stored
);

   reg [31:0] mem [0:1];     // word 0 physical, word 1 electrical
   reg [1:0]  stored;        // word has been written since reset

   // writes and registered read port
   always @(posedge clock) begin
      if (reset) begin
         mem[0]    <= `SICH_RESET_WORD;
         mem[1]    <= `SICH_RESET_WORD;
         stored    <= 2'h0;
         rd_data   <= `SICH_RESET_WORD;
         rd_stored <= 1'b0;
      end else begin
         if (wr_en) begin
            mem[wr_sel]    <= wr_data;
            stored[wr_sel] <= 1'b1;
         end
         rd_data   <= mem[rd_sel];
         rd_stored <= stored[rd_sel];
      end
   end

endmodule // sich_value_store
`default_nettype wire

// ==== verilog/sich_tx_shifter.v ====
// reply byte serialiser, most significant byte first
`timescale 1ns/1ps
`default_nettype none
`include "sich_regs.vh"

module sich_tx_shifter (
   // clock and reset
   input  wire        clock,
   input  wire        reset,
   // load side: bytes stand left aligned in load_data
   input  wire        load,
   input  wire [2:0]  load_count,
   input  wire [31:0] load_data,
   output wire        busy,
   // byte stream out
   output wire        tx_valid,
   output wire [7:0]  tx_data,
   input  wire        tx_ready
);

   reg [31:0] shreg;   // pending reply bytes
   reg [2:0]  left;    // bytes still to send

   assign busy     = (left != 3'h0);
   assign tx_valid = busy;
   assign tx_data  = shreg[31:24];

   // load a reply, then shift one byte out per accepted transfer
   always @(posedge clock) begin
      if (reset) begin
         shreg <= `SICH_RESET_WORD;
         left  <= 3'h0;
      end else if (load) begin
         shreg <= load_data;
         left  <= load_count;
      end else if (tx_valid && tx_ready) begin
         shreg <= {shreg[23:0], 8'h00};
         left  <= left - 3'h1;
      end
   end

endmodule // sich_tx_shifter
`default_nettype wire

// ==== verilog/sich_command_handler.v ====
// serial command handler for sensor information commands of a bridge amplifier
`timescale 1ns/1ps
`default_nettype none
`include "sich_regs.vh"

module sich_command_handler #(
   parameter [23:0] SENS_POS1_LVL1 = 24'h00_0064,  // 1 mV/V times 100
   parameter [23:0] SENS_POS2_LVL1 = 24'h00_00C8,  // 2 mV/V times 100
   parameter [23:0] SENS_POS2_LVL2 = 24'h00_015E,  // 3.5 mV/V times 100
   parameter [23:0] SENS_CH1       = 24'h0F_4240,  // 10 V as 10000 mV times 100
   parameter [7:0]  SENS_EXPONENT  = 8'h01         // exponent byte matching the fitted ranges
) (
   // clock and reset
   input  wire        clock,
   input  wire        reset,
   // command byte stream in
   input  wire        rx_valid,
   input  wire [7:0]  rx_data,
   output wire        rx_ready,
   // reply byte stream out
   output wire        tx_valid,
   output wire [7:0]  tx_data,
   input  wire        tx_ready,
   // device state consulted by the commands
   input  wire        cmd_blocked,
   input  wire [15:0] learn_remaining,
   input  wire        jumper_position2,
   input  wire        level_second,
   input  wire        channel1_active,
   input  wire [7:0]  assigned_record,
   input  wire [5:0]  text_valid,
   // status to the rest of the device
   output wire        handler_busy,
   output reg         cmd_unknown
);

   // controller states
   localparam [1:0] ST_IDLE  = 2'h0;  // wait for a command byte
   localparam [1:0] ST_PARAM = 2'h1;  // collect parameter bytes
   localparam [1:0] ST_EXEC  = 2'h2;  // evaluate and load the reply
   localparam [1:0] ST_SEND  = 2'h3;  // wait until the reply is out

   reg  [1:0]  state;          // controller state
   reg  [1:0]  next_state;     // controller state, next value
   reg  [7:0]  cmd;            // command being handled
   reg  [2:0]  par_left;       // parameter bytes still expected
   reg  [31:0] par;            // parameter bytes, first byte highest
   reg  [31:0] reply;          // reply bytes, left aligned
   reg  [2:0]  reply_count;    // number of reply bytes
   reg         store_en;       // write a characteristic value
   reg         load;           // start sending the reply
   wire        tx_busy;        // serialiser still holds bytes
   wire [31:0] stored_value;   // value read back from the store
   wire        stored_ok;      // that value was written since reset
   wire        rd_sel;         // which value to read
   wire        rx_take;        // byte accepted this cycle
   reg  [2:0]  npar;           // parameter count of an incoming command
   reg         known;          // incoming command is one of ours

   // true when lo <= value <= hi
   function in_range;
      input [23:0] value;
      input [23:0] lo;
      input [23:0] hi;
      begin
         in_range = (value >= lo) && (value <= hi);
      end
   endfunction

   // parameter count of a command byte, and whether it is handled here
   always @* begin
      npar  = 3'h0;
      known = 1'b1;
      case (rx_data)
         `SICH_CMD_RANGES:      npar = `SICH_NPAR_RANGES;
         `SICH_CMD_SET_CAPACITY: npar = `SICH_NPAR_SET_VALUE;
         `SICH_CMD_SET_RATED:   npar = `SICH_NPAR_SET_VALUE;
         `SICH_CMD_LEARN_LEFT,
         `SICH_CMD_GET_CAPACITY,
         `SICH_CMD_GET_RATED,
         `SICH_CMD_TEXT_ASSIGN: npar = 3'h0;
         default:               known = 1'b0;
      endcase
   end

   assign rx_ready     = (state == ST_IDLE) || (state == ST_PARAM);
   assign rx_take      = rx_valid && rx_ready;
   assign handler_busy = (state != ST_IDLE);
   // while idle, select by the incoming byte so the registered read is right during EXEC
   assign rd_sel       = (state == ST_IDLE) ? (rx_data == `SICH_CMD_GET_RATED) :
                                              (cmd == `SICH_CMD_GET_RATED);

   // command reception: command byte then parameters, all raw binary
   always @(posedge clock) begin
      if (reset) begin
         cmd         <= `SICH_RESET_BYTE;
         par_left    <= 3'h0;
         par         <= `SICH_RESET_WORD;
         cmd_unknown <= 1'b0;
      end else begin
         cmd_unknown <= 1'b0;
         if (rx_take) begin
            if (state == ST_IDLE) begin
               // first byte of a frame is the command number
               cmd         <= rx_data;
               par_left    <= npar;
               par         <= `SICH_RESET_WORD;
               cmd_unknown <= !known;
            end else begin
               // parameters are taken as binary values, no digit decoding
               par      <= {par[23:0], rx_data};
               par_left <= par_left - 3'h1;
            end
         end
      end
   end

   // state sequencing
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (rx_take && known) begin
               next_state = (npar == 3'h0) ? ST_EXEC : ST_PARAM;
            end
         end
         ST_PARAM: begin
            if (rx_take && (par_left == 3'h1)) begin
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            next_state = (reply_count == 3'h0) ? ST_IDLE : ST_SEND;
         end
         ST_SEND: begin
            if (!tx_busy) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // state register
   always @(posedge clock) begin
      if (reset) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // reply evaluation for each command
   always @* begin
      reply       = `SICH_RESET_WORD;
      reply_count = `SICH_NREP_NONE;
      store_en    = 1'b0;
      if (cmd_blocked) begin
         // device cannot serve the command now
         reply       = {`SICH_ERR_BUSY, 24'h00_0000};
         reply_count = `SICH_NREP_ERROR;
      end else begin
         case (cmd)
            `SICH_CMD_LEARN_LEFT: begin
               // count is zero once done or if never started
               reply       = {learn_remaining, 16'h0000};
               reply_count = `SICH_NREP_LEARN;
            end
            `SICH_CMD_RANGES: begin
               // high nibble channel (bit 4 only), low nibble level
               reply_count = `SICH_NREP_RANGES;
               case (par[7:0])
                  `SICH_RQ_CURRENT: begin
                     if (!jumper_position2) begin
                        reply = {`SICH_GID_POS1, SENS_POS1_LVL1};
                     end else if (!level_second) begin
                        reply = {`SICH_GID_POS2, SENS_POS2_LVL1};
                     end else begin
                        reply = {`SICH_GID_POS2, SENS_POS2_LVL2};
                     end
                  end
                  `SICH_RQ_POS1_LVL1: reply = {`SICH_GID_POS1, SENS_POS1_LVL1};
                  `SICH_RQ_POS2_LVL1: reply = {`SICH_GID_POS2, SENS_POS2_LVL1};
                  `SICH_RQ_POS2_LVL2: reply = {`SICH_GID_POS2, SENS_POS2_LVL2};
                  `SICH_RQ_CH1: reply = {`SICH_GID_CH1, SENS_CH1};
                  `SICH_RQ_CH1_ACTIVE: begin
                     if (channel1_active) begin
                        reply = {`SICH_GID_CH1, SENS_CH1};
                     end else begin
                        reply       = {`SICH_ERR_RANGE_PARAM, 24'h00_0000};
                        reply_count = `SICH_NREP_ERROR;
                     end
                  end
                  default: begin
                     // unsupported channel or level code
                     reply       = {`SICH_ERR_RANGE_PARAM, 24'h00_0000};
                     reply_count = `SICH_NREP_ERROR;
                  end
               endcase
            end
            `SICH_CMD_GET_CAPACITY,
            `SICH_CMD_GET_RATED: begin
               if (stored_ok) begin
                  // exponent byte as stored then mantissa, high byte first
                  reply       = stored_value;
                  reply_count = `SICH_NREP_VALUE;
               end else begin
                  // nothing stored yet
                  reply       = {`SICH_ERR_NO_VALUE, 24'h00_0000};
                  reply_count = `SICH_NREP_ERROR;
               end
            end
            `SICH_CMD_SET_CAPACITY: begin
               if (par[31:24] > `SICH_CAP_EXP_MAX) begin
                  reply       = {`SICH_ERR_EXPONENT, 24'h00_0000};
                  reply_count = `SICH_NREP_ERROR;
               end else if (!in_range(par[23:0], `SICH_CAP_MANT_MIN, `SICH_MANT_MAX)) begin
                  reply       = {`SICH_ERR_MANTISSA, 24'h00_0000};
                  reply_count = `SICH_NREP_ERROR;
               end else begin
                  store_en = 1'b1;
               end
            end
            `SICH_CMD_SET_RATED: begin
               if (par[31:24] > `SICH_RATED_EXP_MAX) begin
                  reply       = {`SICH_ERR_EXPONENT, 24'h00_0000};
                  reply_count = `SICH_NREP_ERROR;
               end else if (par[31:24] != SENS_EXPONENT) begin
                  // exponent must fit the fitted sensitivity range
                  reply       = {`SICH_ERR_MISMATCH, 24'h00_0000};
                  reply_count = `SICH_NREP_ERROR;
               end else if (!in_range(par[23:0], `SICH_RATED_MANT_MIN, `SICH_MANT_MAX)) begin
                  reply       = {`SICH_ERR_MANTISSA, 24'h00_0000};
                  reply_count = `SICH_NREP_ERROR;
               end else begin
                  store_en = 1'b1;
               end
            end
            `SICH_CMD_TEXT_ASSIGN: begin
               // record number (0 = none) and text presence flags
               reply       = {assigned_record, 2'b00, text_valid, 16'h0000};
               reply_count = `SICH_NREP_ASSIGN;
            end
            default: begin
               reply_count = `SICH_NREP_NONE;
            end
         endcase
      end
      load = (state == ST_EXEC) && (reply_count != 3'h0);
   end

   // characteristic value storage
   sich_value_store u_store (
      .clock     (clock),
      .reset     (reset),
      .wr_en     ((state == ST_EXEC) && store_en),
      .wr_sel    (cmd == `SICH_CMD_SET_RATED),
      .wr_data   (par),
      .rd_sel    (rd_sel),
      .rd_data   (stored_value),
      .rd_stored (stored_ok)
   );

   // reply serialiser
   sich_tx_shifter u_tx (
      .clock      (clock),
      .reset      (reset),
      .load       (load),
      .load_count (reply_count),
      .load_data  (reply),
      .busy       (tx_busy),
      .tx_valid   (tx_valid),
      .tx_data    (tx_data),
      .tx_ready   (tx_ready)
   );

endmodule // sich_command_handler
`default_nettype wire

// ==== dv/sich_chk.sv ====
// port assertions of the sensor info command handler
`timescale 1ns/1ps
`default_nettype none
module sich_chk (
   // clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // byte streams
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_data,
   input wire logic        rx_ready,
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_ready,
   // device state
   input wire logic        cmd_blocked,
   input wire logic [15:0] learn_remaining,
   input wire logic [7:0]  assigned_record,
   // status
   input wire logic        handler_busy,
   input wire logic        cmd_unknown
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic       take;   // command byte taken while idle
   logic [7:0] lr_hi;  // high byte of the learn count
   assign take = rx_valid && rx_ready && !handler_busy;
   assign lr_hi = learn_remaining[15:8];
   property p_rst_idle;
      $fell(reset) |-> !tx_valid && rx_ready && !handler_busy && !cmd_unknown;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
   property p_ready;
      !rx_ready |-> handler_busy;
   endproperty
   a_ready: assert property (p_ready) else $error("input refused while idle");
   property p_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_hold: assert property (p_hold) else $error("reply byte lost during stall");
   property p_tx_lock;
      tx_valid |-> !rx_ready;
   endproperty
   a_tx_lock: assert property (p_tx_lock) else $error("input open while replying");
   property p_unk;
      cmd_unknown |-> !handler_busy && !tx_valid ##1 !cmd_unknown;
   endproperty
   a_unk: assert property (p_unk) else $error("unknown command pulse wrong");
   property p_reply2;
      take && rx_data inside {8'hA1, 8'hA4, 8'hA6, 8'hA8} |-> ##1 !tx_valid ##1 tx_valid;
   endproperty
   a_reply2: assert property (p_reply2) else $error("reply latency wrong");
   property p_blocked;
      take && rx_data == 8'hA4 ##1 cmd_blocked |=> tx_valid && tx_data == 8'hA0;
   endproperty
   a_blocked: assert property (p_blocked) else $error("blocked read not refused");
   property p_learn;
      take && rx_data == 8'hA1 ##1 !cmd_blocked |=> tx_valid && tx_data == $past(lr_hi);
   endproperty
   a_learn: assert property (p_learn) else $error("learn count high byte wrong");
   property p_assign;
      take && rx_data == 8'hA8 ##1 !cmd_blocked |=> tx_data == $past(assigned_record);
   endproperty
   a_assign: assert property (p_assign) else $error("record number wrong");
   c_unknown: cover property (cmd_unknown);
   c_stall: cover property (tx_valid && !tx_ready);
   c_nodata: cover property (tx_valid && tx_data == 8'h91);
endmodule // sich_chk
`default_nettype wire

// ==== dv/sich_host_model.sv ====
// host side model: takes reply bytes, stalling at random, and logs them
`timescale 1ns/1ps
`default_nettype none
module sich_host_model (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // stall enable from the bench
   input  wire logic       stall,
   // reply stream
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output var  logic       tx_ready
);
   logic [7:0] got [$];  // reply bytes in arrival order
   initial tx_ready = 1'b1;
   // ready moves on the falling edge only
   always @(negedge clock) tx_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
   // log each byte taken on a rising edge
   always @(posedge clock) if (!reset && tx_valid && tx_ready) got.push_back(tx_data);
endmodule // sich_host_model
`default_nettype wire

// ==== dv/sich_command_handler_test.sv ====
// self-checking bench of the sensor info command handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module sich_command_handler_test;
   logic        clock, reset, rx_valid, rx_ready, tx_valid, tx_ready, cmd_blocked, stall;
   logic        jumper_position2, level_second, channel1_active, handler_busy, cmd_unknown;
   logic [7:0]  rx_data, tx_data, assigned_record;
   logic [15:0] learn_remaining;
   logic [5:0]  text_valid;
   logic [31:0] cap, rat;         // model copies of stored values
   bit          cap_ok, rat_ok, lz; // model flags, lz forces a zero count
   logic [7:0]  exq [$];          // expected reply bytes
   int          error_cnt, samples_checked;
   logic [7:0]  rq [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h04, 8'h12, 8'h20};
   logic [31:0] cw [6] = '{32'h0798_967F, 32'h0001_86A0, 32'h0801_86A0, 32'h0001_869F,
                           32'h0098_9680, 32'h0326_25A0};
   logic [31:0] rw [6] = '{32'h0100_2710, 32'h0198_967F, 32'h0401_0000, 32'h0201_0000,
                           32'h0100_270F, 32'h0198_9680};
   sich_command_handler dut (.clock(clock), .reset(reset), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .cmd_blocked(cmd_blocked), .learn_remaining(learn_remaining),
      .jumper_position2(jumper_position2), .level_second(level_second),
      .channel1_active(channel1_active), .assigned_record(assigned_record),
      .text_valid(text_valid), .handler_busy(handler_busy), .cmd_unknown(cmd_unknown));
   sich_host_model host (.clock(clock), .reset(reset), .stall(stall), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // expect the top n bytes of a word, most significant first
   task ex(input logic [31:0] w, input int n);
      for (int i = 3; i > 3 - n; i--) exq.push_back(w[8*i +: 8]);
   endtask
   // offer one byte at a falling edge, return after it was taken
   task put(input logic [7:0] b);
      rx_valid = 1'b1;
      rx_data = b;
      while (!rx_ready) @(negedge clock);
      @(negedge clock);
   endtask
   // one command against the model, replies compared byte by byte
   task run(input logic [7:0] c, input logic [31:0] p, input logic blk);
      logic [7:0] e, g;
      logic [23:0] m;
      int np, k;
      bit unk;
      learn_remaining = lz ? 16'h0000 : 16'($urandom);
      {jumper_position2, level_second, channel1_active, stall} = 4'($urandom);
      assigned_record = 8'($urandom_range(6));
      text_valid = 6'($urandom);
      cmd_blocked = blk;
      np = (c == 8'hA2) ? 1 : (c == 8'hA5 || c == 8'hA7) ? 4 : 0;
      unk = !(c inside {8'hA1, 8'hA2, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8});
      e = p[31:24];
      m = p[23:0];
      g = 8'h00;
      if (blk && !unk) g = 8'hA0;
      else case (c)
         8'hA1: ex({learn_remaining, 16'h0000}, 2);
         8'hA2: begin
            e = p[7:0];
            if (e == 8'h00) e = jumper_position2 ? {7'h01, level_second} : 8'h01;
            if (e == 8'h10 && channel1_active) e = 8'h11;
            case (e)
               8'h01: ex(32'h0100_0064, 4);
               8'h02: ex(32'h0200_00C8, 4);
               8'h03: ex(32'h0200_015E, 4);
               8'h11: ex(32'h030F_4240, 4);
               default: g = 8'h59;
            endcase
         end
         8'hA4: if (cap_ok) ex(cap, 4); else g = 8'h91;
         8'hA6: if (rat_ok) ex(rat, 4); else g = 8'h91;
         8'hA5: if (e > 8'h07) g = 8'h54;
            else if (m < 24'h01_86A0 || m > 24'h98_967F) g = 8'h55;
            else {cap_ok, cap} = {1'b1, p};
         8'hA7: if (e > 8'h03) g = 8'h54;
            else if (e != 8'h01) g = 8'h56;
            else if (m < 24'h00_2710 || m > 24'h98_967F) g = 8'h55;
            else {rat_ok, rat} = {1'b1, p};
         8'hA8: ex({assigned_record, 2'b00, text_valid, 16'h0000}, 2);
         default: ;
      endcase
      if (g != 8'h00) ex({g, 24'h00_0000}, 1);
      put(c);
      for (int i = np - 1; i >= 0; i--) put(p[8*i +: 8]);
      rx_valid = 1'b0;
      if (unk) `CHK(cmd_unknown, 1'b1)
      k = 0;
      while ((handler_busy || tx_valid) && k < 200) begin
         @(negedge clock);
         k++;
      end
      if (k == 200) error_cnt++;
      `CHK(host.got.size(), exq.size())
      foreach (exq[i]) if (i < host.got.size()) `CHK(host.got[i], exq[i])
      host.got.delete();
      exq.delete();
      // let an edge pass so the next command never re-raises rx_valid in this step
      @(negedge clock);
   endtask
   initial begin
      void'($urandom(32'hdef3_56c2));
      reset = 1'b1;
      {rx_valid, rx_data, cmd_blocked, learn_remaining, jumper_position2, level_second,
       channel1_active, assigned_record, text_valid, stall} = '0;
      repeat (3) @(negedge clock);
      reset = 1'b0;
      repeat (2) run(8'hA1, 0, 0);
      lz = 1;
      run(8'hA1, 0, 0);
      lz = 0;
      $display("test learn count done");
      run(8'hA4, 0, 0);
      run(8'hA6, 0, 0);
      $display("test empty reads done");
      for (int r = 0; r < 4; r++) foreach (rq[i]) run(8'hA2, {24'h0, rq[i]}, 0);
      $display("test ranges done");
      run(8'hA2, 0, 0);
      foreach (cw[i]) begin
         run(8'hA5, cw[i], 0);
         run(8'hA4, 0, 0);
         run(8'hA7, rw[i], 0);
         run(8'hA6, 0, 0);
      end
      repeat (4) begin
         run(8'hA5, {8'($urandom_range(7)), 24'($urandom_range(24'h98967F, 24'h186A0))}, 0);
         run(8'hA4, 0, 0);
         run(8'hA7, {8'h01, 24'($urandom_range(24'h98967F, 24'h2710))}, 0);
         run(8'hA6, 0, 0);
      end
      $display("test stored values done");
      foreach (rq[i]) run(8'hA0 + rq[i][3:0], 32'h0001_86A0, 1);
      run(8'hA5, 32'h0001_86A0, 1);
      run(8'hA7, 32'h0100_2710, 1);
      run(8'hA4, 0, 0);
      run(8'hA6, 0, 0);
      $display("test blocked done");
      repeat (4) run(8'hA8, 0, 0);
      $display("test assignment done");
      run(8'h00, 0, 0);
      run(8'hA3, 0, 0);
      run(8'hFF, 0, 0);
      run(8'hA1, 0, 0);
      $display("test unknown commands done");
      reset = 1'b1;
      {cap_ok, rat_ok} = 2'b00;
      repeat (3) @(negedge clock);
      reset = 1'b0;
      run(8'hA4, 0, 0);
      run(8'hA6, 0, 0);
      $display("test second reset done");
      stop_test;
   end
   initial begin
      #100000;
      error_cnt++;
      stop_test;
   end
endmodule // sich_command_handler_test
bind sich_command_handler sich_chk chk (.clock(clock), .reset(reset), .rx_valid(rx_valid),
   .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
   .tx_ready(tx_ready), .cmd_blocked(cmd_blocked), .learn_remaining(learn_remaining),
   .assigned_record(assigned_record), .handler_busy(handler_busy),
   .cmd_unknown(cmd_unknown));
`default_nettype wire
